// file: src/adcsc_pkg.sv
// constants and carrier types shared by the conversion control block
package adcsc_pkg;
    // register byte offsets on the lite bus
    localparam logic [7:0] OFF_CONV_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFF_CONV_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h08;
    localparam logic [7:0] OFF_RESULT_LOW_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // reset values
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h10;
    localparam logic [7:0] CONTROL_TWO_RESET = 8'h10;

    // mode field encodings
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_SOFT_START = 2'h1;
    localparam logic [1:0] MODE_RESERVED = 2'h2;
    localparam logic [1:0] MODE_REPEAT = 2'h3;

    // conversion time codes
    localparam logic [2:0] TIME_CODE_39 = 3'h0;
    localparam logic [2:0] TIME_CODE_78 = 3'h2;
    localparam logic [2:0] TIME_CODE_156 = 3'h3;
    localparam logic [2:0] TIME_CODE_312 = 3'h4;
    localparam logic [2:0] TIME_CODE_624 = 3'h5;
    localparam logic [2:0] TIME_CODE_1248 = 3'h6;

    // conversion lengths in main-clock periods; aclk is that clock
    localparam int CONV_FC_39 = 39;
    localparam int CONV_FC_78 = 78;
    localparam int CONV_FC_156 = 156;
    localparam int CONV_FC_312 = 312;
    localparam int CONV_FC_624 = 624;
    localparam int CONV_FC_1248 = 1248;
    localparam int FC_PER_ACLK = 1;
    localparam int COUNT_WIDTH = 11;
    localparam logic [10:0] CYC_39 = 11'(CONV_FC_39 / FC_PER_ACLK);
    localparam logic [10:0] CYC_78 = 11'(CONV_FC_78 / FC_PER_ACLK);
    localparam logic [10:0] CYC_156 = 11'(CONV_FC_156 / FC_PER_ACLK);
    localparam logic [10:0] CYC_312 = 11'(CONV_FC_312 / FC_PER_ACLK);
    localparam logic [10:0] CYC_624 = 11'(CONV_FC_624 / FC_PER_ACLK);
    localparam logic [10:0] CYC_1248 = 11'(CONV_FC_1248 / FC_PER_ACLK);

    // successive approximation: one decision per cycle at the tail
    localparam int RESULT_WIDTH = 10;
    localparam logic [10:0] DECIDE_CYCLES = 11'h00a;
    localparam logic [9:0] FIRST_TRIAL = 10'h200;

    // interrupt status bit
    localparam int IRQ_BIT_DONE = 0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic conv_start_bit;
        logic [1:0] conv_mode_field;
        logic analog_input_disable;
        logic [3:0] channel_select;
    } adcsc_ctrl_one_t;

    typedef struct packed {
        logic [1:0] unused;
        logic ladder_always_on;
        logic fixed_one;
        logic [2:0] conv_time;
        logic fixed_zero;
    } adcsc_ctrl_two_t;

    typedef struct packed {
        logic [1:0] result_low;
        logic conv_end_flag;
        logic conv_busy_flag;
        logic [3:0] unused;
    } adcsc_low_status_t;
endpackage : adcsc_pkg

// file: src/adcsc_sar.sv
// successive approximation engine: sample phase then ten decisions
`timescale 1ns/1ps
`default_nettype none
module adcsc_sar (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic start,
    input wire logic abort,
    input wire logic [10:0] conv_cycles,
    // analog side
    input wire logic comp_in,
    output logic [9:0] dac_code,
    output logic sampling,
    // status
    output logic busy,
    output logic done,
    output logic [9:0] result
);
    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_SAMPLE = 2'b01,
        SAR_DECIDE = 2'b11
    } adcsc_sar_state_t;

    adcsc_sar_state_t state;
    logic [10:0] count;
    logic [9:0] mask;
    logic [9:0] kept;

    assign busy = (state != SAR_IDLE);
    assign sampling = (state == SAR_SAMPLE);
    // keep the trial bit when the input is at or above the trial level
    assign kept = comp_in ? dac_code : (dac_code & ~mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SAR_IDLE;
            count <= 11'h000;
            mask <= 10'h000;
            dac_code <= 10'h000;
        end else if (abort) begin
            // an aborted conversion never reaches result
            state <= SAR_IDLE;
            dac_code <= 10'h000;
        end else begin
            case (state)
                SAR_IDLE: begin
                    if (start) begin
                        state <= SAR_SAMPLE;
                        count <= conv_cycles - adcsc_pkg::DECIDE_CYCLES - 11'h001;
                    end
                end
                SAR_SAMPLE: begin
                    if (count == 11'h000) begin
                        state <= SAR_DECIDE;
                        mask <= adcsc_pkg::FIRST_TRIAL;
                        dac_code <= adcsc_pkg::FIRST_TRIAL;
                    end else begin
                        count <= count - 11'h001;
                    end
                end
                SAR_DECIDE: begin
                    dac_code <= kept | (mask >> 1);
                    mask <= mask >> 1;
                    if (mask[0]) begin
                        state <= SAR_IDLE;
                        dac_code <= 10'h000;
                    end
                end
                default: state <= SAR_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done <= 1'b0;
            result <= 10'h000;
        end else begin
            done <= 1'b0;
            if (!abort && state == SAR_DECIDE && mask[0]) begin
                done <= 1'b1;
                result <= kept;
            end
        end
    end
endmodule : adcsc_sar
`default_nettype wire

// file: src/adcsc_top.sv
// conversion sequencing, control registers and lite bus slave
// What this block does
// - repeat mode start converts same channel continuously
// - completion stores result, sets flag, interrupts
// - repeat mode restarts automatically after completion
// - disable mode aborts at once, no result
// - software mode start bit begins one conversion
// - reading result high clears the end flag
// - restart clears end flag, keeps old result
// - standby aborts, resets controls, loses results
// - after standby stay idle until started
// - standby disconnects the analog reference ladder
// - ten-bit result split high and low
// - mode codes: off, software, reserved, repeat
// - start bit clears itself next cycle, whether or not conversion begins
// - time code picks 39 to 1248 clocks
// - busy flag during conversion, cleared in standby
`timescale 1ns/1ps
`default_nettype none
module adcsc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // lite bus write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // lite bus write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // lite bus write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // lite bus read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // lite bus read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // chip power state: stop or slow standby
    input wire logic standby,
    // analog front end
    input wire logic comp_in,
    output logic [9:0] dac_code,
    output logic sampling,
    output logic [3:0] channel_select,
    output logic analog_input_disable,
    output logic ladder_connect,
    // interrupts
    output logic conv_done_irq,
    output logic irq
);
    adcsc_pkg::adcsc_ctrl_one_t conv_control_one;
    adcsc_pkg::adcsc_ctrl_two_t conv_control_two;
    logic [7:0] result_high_reg;
    logic [1:0] result_low;
    logic conv_end_flag;
    logic conv_busy_flag;
    logic [0:0] irq_status;
    logic [0:0] irq_mask;

    // bus state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_lane0;
    logic wr_mapped;
    logic rd_take;
    logic rd_mapped;
    logic [31:0] next_rdata;

    // engine link
    logic launch;
    logic abort;
    logic sar_done;
    logic [9:0] sar_result;
    logic [10:0] conv_cycles;
    logic mode_write_off;
    logic repeat_again;

    // ---------------- lite bus slave ----------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = do_write && w_strb[0] && !standby;

    always_comb begin
        case (aw_addr)
            adcsc_pkg::OFF_CONV_CONTROL_ONE,
            adcsc_pkg::OFF_CONV_CONTROL_TWO,
            adcsc_pkg::OFF_RESULT_HIGH,
            adcsc_pkg::OFF_RESULT_LOW_STATUS,
            adcsc_pkg::OFF_IRQ_STATUS,
            adcsc_pkg::OFF_IRQ_MASK: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= adcsc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? adcsc_pkg::RESP_OKAY
                                         : adcsc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            adcsc_pkg::OFF_CONV_CONTROL_ONE:
                next_rdata[7:0] = conv_control_one;
            adcsc_pkg::OFF_CONV_CONTROL_TWO:
                next_rdata[5:0] = conv_control_two[5:0];
            adcsc_pkg::OFF_RESULT_HIGH:
                next_rdata[7:0] = result_high_reg;
            adcsc_pkg::OFF_RESULT_LOW_STATUS:
                next_rdata[7:4] = {result_low, conv_end_flag, conv_busy_flag};
            adcsc_pkg::OFF_IRQ_STATUS:
                next_rdata[0] = irq_status[0];
            adcsc_pkg::OFF_IRQ_MASK:
                next_rdata[0] = irq_mask[0];
            default:
                rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= adcsc_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_mapped ? adcsc_pkg::RESP_OKAY
                                     : adcsc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- control registers ----------------
    assign mode_write_off = wr_lane0
        && aw_addr == adcsc_pkg::OFF_CONV_CONTROL_ONE
        && w_data[6:5] == adcsc_pkg::MODE_DISABLED;

    // start is honoured only in software or repeat mode and only when idle
    assign launch = conv_control_one.conv_start_bit && !conv_busy_flag
        && !standby && !mode_write_off
        && (conv_control_one.conv_mode_field == adcsc_pkg::MODE_SOFT_START
         || conv_control_one.conv_mode_field == adcsc_pkg::MODE_REPEAT);

    assign abort = standby || mode_write_off;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_control_one <= adcsc_pkg::CONTROL_ONE_RESET;
        end else if (standby) begin
            conv_control_one <= adcsc_pkg::CONTROL_ONE_RESET;
        end else if (wr_lane0 && aw_addr == adcsc_pkg::OFF_CONV_CONTROL_ONE) begin
            conv_control_one <= w_data[7:0];
        end else if (conv_control_one.conv_start_bit) begin
            // a restart while busy is dropped rather than queued
            conv_control_one.conv_start_bit <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_control_two <= adcsc_pkg::CONTROL_TWO_RESET;
        end else if (standby) begin
            conv_control_two <= adcsc_pkg::CONTROL_TWO_RESET;
        end else if (wr_lane0 && aw_addr == adcsc_pkg::OFF_CONV_CONTROL_TWO) begin
            conv_control_two.ladder_always_on <= w_data[5];
            conv_control_two.conv_time <= w_data[3:1];
        end
    end

    // reserved time codes fall back to the longest, safest length
    always_comb begin
        case (conv_control_two.conv_time)
            adcsc_pkg::TIME_CODE_39: conv_cycles = adcsc_pkg::CYC_39;
            adcsc_pkg::TIME_CODE_78: conv_cycles = adcsc_pkg::CYC_78;
            adcsc_pkg::TIME_CODE_156: conv_cycles = adcsc_pkg::CYC_156;
            adcsc_pkg::TIME_CODE_312: conv_cycles = adcsc_pkg::CYC_312;
            adcsc_pkg::TIME_CODE_624: conv_cycles = adcsc_pkg::CYC_624;
            adcsc_pkg::TIME_CODE_1248: conv_cycles = adcsc_pkg::CYC_1248;
            default: conv_cycles = adcsc_pkg::CYC_1248;
        endcase
    end

    // ---------------- conversion engine ----------------
    adcsc_sar u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(launch || repeat_again),
        .abort(abort),
        .conv_cycles(conv_cycles),
        .comp_in(comp_in),
        .dac_code(dac_code),
        .sampling(sampling),
        .busy(),
        .done(sar_done),
        .result(sar_result)
    );

    // the channel is held in control one, so every repeat uses the same input
    assign repeat_again = sar_done && !abort
        && conv_control_one.conv_mode_field == adcsc_pkg::MODE_REPEAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_busy_flag <= 1'b0;
        end else if (abort) begin
            conv_busy_flag <= 1'b0;
        end else if (launch || repeat_again) begin
            conv_busy_flag <= 1'b1;
        end else if (sar_done) begin
            conv_busy_flag <= 1'b0;
        end
    end

    // results stay put across a restart until the next completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_high_reg <= 8'h00;
            result_low <= 2'h0;
        end else if (standby) begin
            result_high_reg <= 8'h00;
            result_low <= 2'h0;
        end else if (sar_done) begin
            result_high_reg <= sar_result[9:2];
            result_low <= sar_result[1:0];
        end
    end

    logic read_high;
    assign read_high = rd_take && s_axi_araddr == adcsc_pkg::OFF_RESULT_HIGH;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_end_flag <= 1'b0;
        end else if (standby) begin
            conv_end_flag <= 1'b0;
        end else if (sar_done) begin
            conv_end_flag <= 1'b1;
        end else if (read_high || launch) begin
            conv_end_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_done_irq <= 1'b0;
        end else begin
            conv_done_irq <= sar_done && !standby;
        end
    end

    // ---------------- interrupt status and mask ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 1'b0;
        end else if (sar_done && !standby) begin
            irq_status[adcsc_pkg::IRQ_BIT_DONE] <= 1'b1;
        end else if (wr_lane0 && aw_addr == adcsc_pkg::OFF_IRQ_STATUS
                     && w_data[adcsc_pkg::IRQ_BIT_DONE]) begin
            irq_status[adcsc_pkg::IRQ_BIT_DONE] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= 1'b0;
        end else if (wr_lane0 && aw_addr == adcsc_pkg::OFF_IRQ_MASK) begin
            irq_mask <= w_data[0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ---------------- analog side ----------------
    assign channel_select = conv_control_one.channel_select;
    assign analog_input_disable = conv_control_one.analog_input_disable;
    assign ladder_connect = !standby
        && (conv_control_two.ladder_always_on || conv_busy_flag);
endmodule : adcsc_top
`default_nettype wire

// file: testbench/adcsc_analog_model.sv
// comparator model of the multiplexed analog inputs
`timescale 1ns/1ps
`default_nettype none
module adcsc_analog_model (
    // converter side
    input wire logic [3:0] channel_select,
    input wire logic analog_input_disable,
    input wire logic [9:0] dac_code,
    // comparator
    output logic comp_in
);
    // set by the bench; nothing else on the port pins moves meanwhile
    logic [9:0] level [16];
    initial begin
        foreach (level[i]) level[i] = 10'h000;
    end
    // a disabled input floats, so the comparator sees noise, not a level
    assign comp_in = analog_input_disable ? ^dac_code
                   : (level[channel_select] >= dac_code);
endmodule : adcsc_analog_model
`default_nettype wire

// file: testbench/adcsc_top_monitor.sv
// concurrent checks on the conversion control block ports
`timescale 1ns/1ps
`default_nettype none
module adcsc_top_check (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power and analog side
    input wire logic standby,
    input wire logic sampling,
    input wire logic [9:0] dac_code,
    input wire logic [3:0] channel_select,
    input wire logic analog_input_disable,
    input wire logic ladder_connect,
    input wire logic conv_done_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_done_pulse: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("done pulse longer than one cycle");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    chk_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped early");
    chk_ladder_off: assert property (standby |-> !ladder_connect)
        else $error("ladder connected in standby");
    chk_ladder_busy: assert property (sampling && !standby |-> ladder_connect)
        else $error("ladder open while converting");
    chk_standby_abort: assert property (standby |=> !sampling && dac_code == 10'h000)
        else $error("conversion not aborted in standby");
    chk_standby_ctrl: assert property (standby |=> analog_input_disable && channel_select == 4'h0)
        else $error("control one not reset in standby");
    chk_standby_quiet: assert property (standby |=> !conv_done_irq)
        else $error("done pulse in standby");
    chk_sample_dac: assert property (sampling |-> dac_code == 10'h000)
        else $error("trial code during sample phase");
endmodule : adcsc_top_check

bind adcsc_top adcsc_top_check adcsc_top_check_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .standby(standby), .sampling(sampling),
    .dac_code(dac_code), .channel_select(channel_select),
    .analog_input_disable(analog_input_disable),
    .ladder_connect(ladder_connect), .conv_done_irq(conv_done_irq));
`default_nettype wire

// file: testbench/test_adc_sequence_control.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequence_control;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic [1:0] resp;
    } adcsc_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, standby = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, comp_in, sampling, analog_input_disable;
    logic ladder_connect, conv_done_irq, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [9:0] dac_code;
    logic [3:0] channel_select;
    int errors = 0;
    int check_count = 0, gap;
    adcsc_row_t rows [13];

    always #25 aclk = ~aclk;

    adcsc_top adcsc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby, .comp_in,
        .dac_code, .sampling, .channel_select, .analog_input_disable,
        .ladder_connect, .conv_done_irq, .irq);
    adcsc_analog_model adcsc_analog_model_inst (.channel_select,
        .analog_input_disable, .dac_code, .comp_in);

    task automatic results();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic timed_out(input string what);
        errors++;
        $display("ERROR %s expected answer seen timeout", what);
        results();
    endtask : timed_out

    task automatic compare_val(input string nm, input logic [31:0] e,
                               input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : compare_val

    task automatic compare_resp(input string nm, input logic [1:0] e,
                                input logic [1:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : compare_resp

    // each bus task starts on a fresh edge: no signal is set twice
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] resp);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) timed_out("write");
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) timed_out("read");
    endtask : bus_read

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e,
                           input string nm);
        bus_read(a, rd, rsp);
        compare_val(nm, e, rd);
    endtask : reg_chk

    task automatic wait_done(input int max, output int cyc);
        for (cyc = 1; cyc <= max; cyc++) begin
            @(posedge aclk);
            if (conv_done_irq === 1'b1) break;
        end
        if (cyc > max) timed_out("done pulse");
    endtask : wait_done

    // any pulse here is an unwanted conversion
    task automatic no_pulse(input int n, input string nm);
        int p = 0;
        repeat (n) begin
            @(posedge aclk);
            if (conv_done_irq !== 1'b0) p++;
        end
        compare_val(nm, 32'h0, 32'(p));
    endtask : no_pulse

    function automatic logic [31:0] low_word(input logic [9:0] r,
                                             input logic e, input logic b);
        return {24'h0, r[1:0], e, b, 4'h0};
    endfunction : low_word

    initial begin
        rows[0] = '{1'b0, 8'h00, 32'h0, 32'h10, 2'h0};
        rows[1] = '{1'b0, 8'h04, 32'h0, 32'h10, 2'h0};
        rows[2] = '{1'b0, 8'h08, 32'h0, 32'h0, 2'h0};
        rows[3] = '{1'b0, 8'h0c, 32'h0, 32'h0, 2'h0};
        rows[4] = '{1'b0, 8'h10, 32'h0, 32'h0, 2'h0};
        rows[5] = '{1'b0, 8'h18, 32'h0, 32'h0, 2'h2};
        rows[6] = '{1'b1, 8'h04, 32'h2d, 32'h0, 2'h0};
        rows[7] = '{1'b0, 8'h04, 32'h0, 32'h3c, 2'h0};
        rows[8] = '{1'b1, 8'h18, 32'h1, 32'h0, 2'h2};
        rows[9] = '{1'b1, 8'h14, 32'h1, 32'h0, 2'h0};
        rows[10] = '{1'b0, 8'h14, 32'h0, 32'h1, 2'h0};
        rows[11] = '{1'b1, 8'h0c, 32'hff, 32'h0, 2'h0};
        rows[12] = '{1'b0, 8'h0c, 32'h0, 32'h0, 2'h0};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                bus_write(rows[i].addr, rows[i].data, rsp);
            end else begin
                bus_read(rows[i].addr, rd, rsp);
                compare_val("read data", rows[i].exp, rd);
            end
            compare_resp("response", rows[i].resp, rsp);
        end
        $display("register table test done");
        adcsc_analog_model_inst.level[3] = 10'h2c7;
        bus_write(8'h00, 32'h23, rsp);
        bus_write(8'h04, 32'h00, rsp);
        bus_write(8'h00, 32'ha3, rsp);
        reg_chk(8'h00, 32'h23, "start bit");
        reg_chk(8'h0c, low_word(10'h0, 1'b0, 1'b1), "busy");
        wait_done(200, gap);
        reg_chk(8'h0c, low_word(10'h2c7, 1'b1, 1'b0), "low");
        compare_val("irq", 32'h1, {31'h0, irq});
        bus_write(8'h00, 32'ha3, rsp);
        reg_chk(8'h0c, low_word(10'h2c7, 1'b0, 1'b1), "restart");
        wait_done(100, gap);
        reg_chk(8'h08, 32'h2c7 >> 2, "high");
        reg_chk(8'h0c, low_word(10'h2c7, 1'b0, 1'b0), "flag");
        bus_write(8'h10, 32'h1, rsp);
        compare_val("irq cleared", 32'h0, {31'h0, irq});
        $display("software start test done");
        bus_write(8'h14, 32'h0, rsp);
        adcsc_analog_model_inst.level[5] = 10'h155;
        bus_write(8'h04, 32'h04, rsp);
        bus_write(8'h00, 32'he5, rsp);
        wait_done(300, gap);
        wait_done(100, gap);
        compare_val("gap", 32'h1, {31'h0, gap == 78 || gap == 79});
        adcsc_analog_model_inst.level[5] = 10'h3aa;
        compare_val("channel", 32'h5, {28'h0, channel_select});
        compare_val("masked irq", 32'h0, {31'h0, irq});
        reg_chk(8'h10, 32'h1, "status");
        reg_chk(8'h0c, low_word(10'h155, 1'b1, 1'b1), "kept");
        wait_done(100, gap);
        reg_chk(8'h08, 32'h3aa >> 2, "repeat high");
        adcsc_analog_model_inst.level[5] = 10'h0f0;
        bus_write(8'h00, 32'h05, rsp);
        reg_chk(8'h0c, low_word(10'h3aa, 1'b0, 1'b0), "abort");
        no_pulse(100, "abort pulses");
        reg_chk(8'h08, 32'h3aa >> 2, "abort high");
        $display("repeat and abort test done");
        bus_write(8'h04, 32'h20, rsp);
        bus_write(8'h00, 32'ha3, rsp);
        repeat (5) @(posedge aclk);
        standby <= 1'b1;
        repeat (3) @(posedge aclk);
        compare_val("ladder", 32'h0, {31'h0, ladder_connect});
        standby <= 1'b0;
        reg_chk(8'h00, 32'h10, "standby one");
        reg_chk(8'h04, 32'h10, "standby two");
        reg_chk(8'h08, 32'h0, "standby high");
        reg_chk(8'h0c, 32'h0, "standby low");
        no_pulse(100, "restart pulses");
        $display("standby test done");
        bus_write(8'h00, 32'hc3, rsp);
        no_pulse(100, "reserved pulses");
        reg_chk(8'h0c, 32'h0, "reserved busy");
        $display("reserved mode test done");
        results();
    end
endmodule : test_adc_sequence_control
`default_nettype wire
